/* sto_monitor_map.vh */
/*
  Register indices, field values, reset values and timing constants for the
  torque-off monitor. Assumes inclusion by plain name from the design files.
*/
`ifndef STO_MONITOR_MAP_VH
`define STO_MONITOR_MAP_VH

// ------------------------------------------------------------
// Register indices (16-bit object index, sub-index 0)
// ------------------------------------------------------------
`define REG_SHUTOFF_ALARM_MODE 16'h4190
`define REG_DUAL_CHECK_DELAY 16'h4191
`define REG_RESET_HOLDOFF 16'h4198
`define REG_RESET_CRITERION 16'h4199
`define REG_ALMRST_REEXCITE_EN 16'h419A
`define REG_STOP_REEXCITE_EN 16'h419C

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_SHUTOFF_ALARM_MODE 8'h00
`define RST_DUAL_CHECK_DELAY 8'h00
`define RST_RESET_HOLDOFF 8'h00
`define RST_RESET_CRITERION 8'h01
`define RST_ALMRST_REEXCITE_EN 8'h00
`define RST_STOP_REEXCITE_EN 8'h01

// ------------------------------------------------------------
// Field values
// ------------------------------------------------------------
`define CRIT_ON_EDGE 8'h01
`define CRIT_ON_LEVEL 8'h02
`define DUAL_DELAY_MIN_MS 8'h0B
`define DUAL_DELAY_MAX_MS 8'h64
`define HOLDOFF_MAX_MS 8'h64

// ------------------------------------------------------------
// Timing: one millisecond tick at 125 MHz
// ------------------------------------------------------------
`define CLK_FREQ_HZ 125000000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)

`endif

/* ms_counter.v */
/*
  Millisecond interval counter: counts ticks while running and flags when the
  programmed number of milliseconds has been reached. Assumes a one-cycle tick
  pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module ms_counter #(
  parameter WIDTH = 8
) (
  input wire clk_in,
  input wire reset_in,
  input wire run_in,
  input wire tick_in,
  input wire [WIDTH-1:0] limit_in,
  output reg done_out
);

  reg [WIDTH-1:0] count_q;

  // Restart from zero whenever run drops; saturate once the limit is reached.
  always @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      count_q <= {WIDTH{1'b0}};
      done_out <= 1'b0;
    end else begin
      if (count_q >= limit_in) begin
        done_out <= 1'b1;
      end else if (tick_in) begin
        count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // ms_counter

`default_nettype wire

/* safe_torque_off_monitor.v */
/*
  Torque-off monitor: watches two redundant shutoff inputs, raises alarms and
  governs re-excitation of the motor. Registers are reached through a simple
  index/strobe port. Assumes shutoff, reset, alarm-reset and stop inputs are
  asynchronous pins; the register port is synchronous to CLK_IN.

  // How it works
  // - Mode 1 alarms when either shutoff input turns off; mode 0 never.
  // - Other input must follow off within 11..100 ms delay; 0..10 disables.
  // - Shutoff-reset re-excites only when both shutoff inputs are on.
  // - After both on, shutoff-reset ignored until hold-off period elapses.
  // - Criterion 1 re-excites on reset rising edge; 2 while level on.
  // - Alarm-reset rising edge re-excites when enabled; default disabled.
  // - Stop rising edge re-excites when enabled; default enabled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sto_monitor_map.vh"

module safe_torque_off_monitor #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire CLK_IN,
  input wire RESET_IN,
  input wire FIRST_SHUTOFF_INPUT_IN,
  input wire SECOND_SHUTOFF_INPUT_IN,
  input wire SHUTOFF_RESET_INPUT_IN,
  input wire ALARM_RESET_INPUT_IN,
  input wire STOP_INPUT_IN,
  input wire [15:0] REG_INDEX_IN,
  input wire REG_WRITE_IN,
  input wire REG_READ_IN,
  input wire [7:0] REG_WDATA_IN,
  output reg [7:0] REG_RDATA_OUT,
  output reg REG_RVALID_OUT,
  output reg REG_ERROR_OUT,
  output reg TORQUE_OFF_STATE_OUT,
  output reg SHUTOFF_ALARM_OUT,
  output reg DUAL_CHANNEL_ALARM_OUT
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [4:0] prev_q;
  wire [4:0] raw_in;
  assign raw_in = {STOP_INPUT_IN, ALARM_RESET_INPUT_IN, SHUTOFF_RESET_INPUT_IN,
                   SECOND_SHUTOFF_INPUT_IN, FIRST_SHUTOFF_INPUT_IN};

  // Two stages per pin; only the second stage and its delayed copy are read.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge CLK_IN) begin
        if (RESET_IN) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  wire first_on;
  wire second_on;
  wire reset_level;
  wire reset_rise;
  wire almrst_rise;
  wire stop_rise;
  wire both_on;
  wire any_fall;
  assign first_on = sync2_q[0];
  assign second_on = sync2_q[1];
  assign reset_level = sync2_q[2];
  assign reset_rise = sync2_q[2] & ~prev_q[2];
  assign almrst_rise = sync2_q[3] & ~prev_q[3];
  assign stop_rise = sync2_q[4] & ~prev_q[4];
  assign both_on = first_on & second_on;
  assign any_fall = (prev_q[0] & ~first_on) | (prev_q[1] & ~second_on);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] alarm_mode_q;
  reg [7:0] dual_delay_q;
  reg [7:0] holdoff_q;
  reg [7:0] criterion_q;
  reg [7:0] almrst_en_q;
  reg [7:0] stop_en_q;
  reg hit_d;

  // Address decode for the index port.
  always @* begin
    case (REG_INDEX_IN)
      `REG_SHUTOFF_ALARM_MODE, `REG_DUAL_CHECK_DELAY, `REG_RESET_HOLDOFF,
      `REG_RESET_CRITERION, `REG_ALMRST_REEXCITE_EN, `REG_STOP_REEXCITE_EN: begin
        hit_d = 1'b1;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // Writes store the full byte; unknown indices flag an error for one cycle.
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      alarm_mode_q <= `RST_SHUTOFF_ALARM_MODE;
      dual_delay_q <= `RST_DUAL_CHECK_DELAY;
      holdoff_q <= `RST_RESET_HOLDOFF;
      criterion_q <= `RST_RESET_CRITERION;
      almrst_en_q <= `RST_ALMRST_REEXCITE_EN;
      stop_en_q <= `RST_STOP_REEXCITE_EN;
    end else if (REG_WRITE_IN) begin
      case (REG_INDEX_IN)
        `REG_SHUTOFF_ALARM_MODE: alarm_mode_q <= REG_WDATA_IN;
        `REG_DUAL_CHECK_DELAY: dual_delay_q <= REG_WDATA_IN;
        `REG_RESET_HOLDOFF: holdoff_q <= REG_WDATA_IN;
        `REG_RESET_CRITERION: criterion_q <= REG_WDATA_IN;
        `REG_ALMRST_REEXCITE_EN: almrst_en_q <= REG_WDATA_IN;
        `REG_STOP_REEXCITE_EN: stop_en_q <= REG_WDATA_IN;
        default: alarm_mode_q <= alarm_mode_q;
      endcase
    end
  end

  // Read data answers one cycle after the strobe.
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
      REG_ERROR_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_READ_IN;
      REG_ERROR_OUT <= (REG_READ_IN | REG_WRITE_IN) & ~hit_d;
      case (REG_INDEX_IN)
        `REG_SHUTOFF_ALARM_MODE: REG_RDATA_OUT <= alarm_mode_q;
        `REG_DUAL_CHECK_DELAY: REG_RDATA_OUT <= dual_delay_q;
        `REG_RESET_HOLDOFF: REG_RDATA_OUT <= holdoff_q;
        `REG_RESET_CRITERION: REG_RDATA_OUT <= criterion_q;
        `REG_ALMRST_REEXCITE_EN: REG_RDATA_OUT <= almrst_en_q;
        `REG_STOP_REEXCITE_EN: REG_RDATA_OUT <= stop_en_q;
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  reg [17:0] tick_cnt_q;
  reg tick_q;

  // Shared time base keeps both timers coarse but cheap.
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      tick_cnt_q <= 18'h0_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 18'h0_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h0_0001;
      tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Alarms
  // ------------------------------------------------------------
  wire mismatch;
  wire dual_enabled;
  wire dual_done;
  // Re-excitation terms are declared here because the alarm clear reads them.
  wire holdoff_done;
  reg reexcite_d;
  reg reset_ok_d;
  assign mismatch = first_on ^ second_on;
  assign dual_enabled = (dual_delay_q >= `DUAL_DELAY_MIN_MS) && (dual_delay_q <= `DUAL_DELAY_MAX_MS);

  ms_counter #(.WIDTH(8)) u_dual_timer (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .run_in(mismatch & dual_enabled),
    .tick_in(tick_q),
    .limit_in(dual_delay_q),
    .done_out(dual_done)
  );

  // Alarms latch until both inputs are on and a re-excitation is accepted.
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      SHUTOFF_ALARM_OUT <= 1'b0;
      DUAL_CHANNEL_ALARM_OUT <= 1'b0;
    end else begin
      if (alarm_mode_q == 8'h01 && any_fall) begin
        SHUTOFF_ALARM_OUT <= 1'b1;
      end else if (reexcite_d) begin
        SHUTOFF_ALARM_OUT <= 1'b0;
      end
      if (dual_done) begin
        DUAL_CHANNEL_ALARM_OUT <= 1'b1;
      end else if (reexcite_d) begin
        DUAL_CHANNEL_ALARM_OUT <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Re-excitation control
  // ------------------------------------------------------------
  ms_counter #(.WIDTH(8)) u_holdoff_timer (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .run_in(both_on & TORQUE_OFF_STATE_OUT),
    .tick_in(tick_q),
    .limit_in(holdoff_q),
    .done_out(holdoff_done)
  );

  // Reset input is judged only after hold-off; other paths need both inputs on.
  always @* begin
    case (criterion_q)
      `CRIT_ON_EDGE: reset_ok_d = reset_rise;
      `CRIT_ON_LEVEL: reset_ok_d = reset_level;
      default: reset_ok_d = 1'b0;
    endcase
    reexcite_d = both_on & TORQUE_OFF_STATE_OUT &
                 ((holdoff_done & reset_ok_d) |
                  (almrst_en_q == 8'h01 & almrst_rise) |
                  (stop_en_q == 8'h01 & stop_rise));
  end

  // Torque-off wins whenever a shutoff input is off.
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      TORQUE_OFF_STATE_OUT <= 1'b1;
    end else if (!both_on) begin
      TORQUE_OFF_STATE_OUT <= 1'b1;
    end else if (reexcite_d) begin
      TORQUE_OFF_STATE_OUT <= 1'b0;
    end
  end

endmodule // safe_torque_off_monitor

`default_nettype wire

/* sto_chk_properties.sv */
/* Port checker for the torque-off monitor.
   Assumes it is bound to the top module and shares its single clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module sto_chk (
  input wire logic CLK_IN, RESET_IN, FIRST_SHUTOFF_INPUT_IN, SECOND_SHUTOFF_INPUT_IN,
  input wire logic STOP_INPUT_IN, ALARM_RESET_INPUT_IN, REG_WRITE_IN, REG_READ_IN,
  input wire logic [15:0] REG_INDEX_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_RVALID_OUT, REG_ERROR_OUT, TORQUE_OFF_STATE_OUT,
  input wire logic SHUTOFF_ALARM_OUT, DUAL_CHANNEL_ALARM_OUT
);
  // ----------------------------------------
  // Shadow copies of the settings the properties depend on.
  // ----------------------------------------
  logic [7:0] mode_q, dly_q, stop_q, alm_q;
  wire both_on = FIRST_SHUTOFF_INPUT_IN && SECOND_SHUTOFF_INPUT_IN;
  wire mapped = REG_INDEX_IN inside {16'h4190, 16'h4191, 16'h4198, 16'h4199, 16'h419A, 16'h419C};
  // Writes land one edge after the strobe, as in the block itself.
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      mode_q <= 8'h00;
      dly_q <= 8'h00;
      stop_q <= 8'h01;
      alm_q <= 8'h00;
    end else if (REG_WRITE_IN) begin
      if (REG_INDEX_IN == 16'h4190) mode_q <= REG_WDATA_IN;
      if (REG_INDEX_IN == 16'h4191) dly_q <= REG_WDATA_IN;
      if (REG_INDEX_IN == 16'h419C) stop_q <= REG_WDATA_IN;
      if (REG_INDEX_IN == 16'h419A) alm_q <= REG_WDATA_IN;
    end
  end
  // ----------------------------------------
  // Properties; pins are assumed held steady for several cycles around events.
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  chk_read_answered: assert property (REG_READ_IN |=> REG_RVALID_OUT)
    else $error("read strobe not answered");
  chk_unmapped_flagged: assert property ((REG_READ_IN || REG_WRITE_IN) && !mapped |=> REG_ERROR_OUT)
    else $error("unmapped access not flagged");
  chk_off_keeps_torque: assert property (!FIRST_SHUTOFF_INPUT_IN [*5] |-> TORQUE_OFF_STATE_OUT)
    else $error("motor excited while an input is off");
  chk_excite_needs_both: assert property ($fell(TORQUE_OFF_STATE_OUT) |-> $past(both_on, 3))
    else $error("excited without both inputs on");
  chk_mode_alarm_on: assert property (!SECOND_SHUTOFF_INPUT_IN [*6] ##0 mode_q == 8'h01 |-> SHUTOFF_ALARM_OUT)
    else $error("shutoff alarm missing");
  chk_mode_alarm_off: assert property ($rose(SHUTOFF_ALARM_OUT) |-> mode_q == 8'h01)
    else $error("shutoff alarm in silent mode");
  chk_dual_delay_range: assert property ($rose(DUAL_CHANNEL_ALARM_OUT) |-> dly_q >= 8'h0B && dly_q <= 8'h64)
    else $error("dual alarm while check disabled");
  chk_dual_mismatch: assert property ($rose(DUAL_CHANNEL_ALARM_OUT) |-> $past(FIRST_SHUTOFF_INPUT_IN, 4) !=
    $past(SECOND_SHUTOFF_INPUT_IN, 4))
    else $error("dual alarm with inputs agreeing");
  chk_stop_excites: assert property (stop_q == 8'h01 && $rose(STOP_INPUT_IN) && both_on && $past(both_on, 4) &&
    TORQUE_OFF_STATE_OUT |-> ##[1:6] !TORQUE_OFF_STATE_OUT)
    else $error("stop edge did not excite");
  chk_almrst_excites: assert property (alm_q == 8'h01 && $rose(ALARM_RESET_INPUT_IN) && both_on &&
    $past(both_on, 4) && TORQUE_OFF_STATE_OUT |-> ##[1:6] !TORQUE_OFF_STATE_OUT)
    else $error("alarm reset edge did not excite");
endmodule // sto_chk
`default_nettype wire

/* shutoff_ctrl_model.sv */
/* Model of the external safety controller driving both shutoff lines.
   Assumes the bench commands it; the second line lags by skew cycles or never follows. */
`timescale 1ns/1ps
`default_nettype none
module shutoff_ctrl (
  input wire logic clk_in, shut_in, one_only_in,
  input wire logic [7:0] skew_in,
  output logic first_out, second_out
);
  logic [7:0] cnt_q = 8'h00;
  // Lines change on the falling edge so the block never samples them mid-change.
  initial {first_out, second_out} = 2'b11;
  always @(negedge clk_in) begin
    if (!shut_in) begin
      {first_out, second_out} <= 2'b11;
      cnt_q <= 8'h00;
    end else begin
      first_out <= 1'b0;
      if (!one_only_in && cnt_q >= skew_in) second_out <= 1'b0;
      else cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // shutoff_ctrl
`default_nettype wire

/* tb_top.sv */
/* Self-checking bench for the torque-off monitor.
   Assumes the design files and the checker and controller model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, shut = 0, one_only = 0, clr = 0, almrst = 0, stop = 0, wr_s = 0, rd_s = 0;
  logic [7:0] wdata = 8'h00, skew = 8'h00;
  logic [15:0] idx = 16'h0000;
  wire first_w, second_w, rvalid, err, torque, alarm, dual;
  wire [7:0] rdata;
  int failures = 0, compares = 0;
  // A 4-cycle tick keeps every millisecond count short.
  safe_torque_off_monitor #(.TICK_CYCLES(4)) DUT (.CLK_IN(clk), .RESET_IN(rst),
    .FIRST_SHUTOFF_INPUT_IN(first_w), .SECOND_SHUTOFF_INPUT_IN(second_w), .SHUTOFF_RESET_INPUT_IN(clr),
    .ALARM_RESET_INPUT_IN(almrst), .STOP_INPUT_IN(stop), .REG_INDEX_IN(idx), .REG_WRITE_IN(wr_s),
    .REG_READ_IN(rd_s), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .REG_ERROR_OUT(err), .TORQUE_OFF_STATE_OUT(torque), .SHUTOFF_ALARM_OUT(alarm),
    .DUAL_CHANNEL_ALARM_OUT(dual));
  shutoff_ctrl ctrl (.clk_in(clk), .shut_in(shut), .one_only_in(one_only), .skew_in(skew),
    .first_out(first_w), .second_out(second_w));
  initial forever #4 clk = ~clk;
  // ----------------------------------------
  // Shared tasks; all start and end on a falling edge.
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check1(input string what, input logic seen, exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    idx = i; wdata = d; wr_s = 1'b1; cyc(1); wr_s = 1'b0; cyc(1);
  endtask
  // The answer is settled by the falling edge after the strobe is taken.
  task automatic rd(input logic [15:0] i, input logic [7:0] exp, input logic e);
    idx = i; rd_s = 1'b1; cyc(1); rd_s = 1'b0;
    check("rdata", rdata, exp);
    check1("error", err, e);
    check1("rvalid", rvalid, 1'b1);
    cyc(1);
  endtask
  task automatic off_on;
    shut = 1'b1; cyc(12); shut = 1'b0; cyc(12);
  endtask
  task automatic stop_pulse;
    stop = 1'b1; cyc(6); stop = 1'b0; cyc(2);
  endtask
  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_regs;
    logic [15:0] ri [6] = '{16'h4190, 16'h4191, 16'h4198, 16'h4199, 16'h419A, 16'h419C};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
    for (int k = 0; k < 6; k++) rd(ri[k], rv[k], 1'b0);
    wr(16'h4198, 8'h64);
    rd(16'h4198, 8'h64, 1'b0);
    wr(16'h4192, 8'hFF);
    rd(16'h4192, 8'h00, 1'b1);
  endtask
  task automatic t_stop;
    check1("torque", torque, 1'b1);
    shut = 1'b1; cyc(12);
    check1("alarm", alarm, 1'b0);
    almrst = 1'b1; stop = 1'b1; cyc(6); almrst = 1'b0; stop = 1'b0; cyc(2);
    shut = 1'b0; cyc(12);
    check1("torque", torque, 1'b1);
    almrst = 1'b1; cyc(6); almrst = 1'b0; cyc(2);
    check1("torque", torque, 1'b1);
    stop_pulse();
    check1("torque", torque, 1'b0);
  endtask
  task automatic t_dual(input logic [7:0] d, input logic exp);
    wr(16'h4191, d);
    one_only = 1'b1; shut = 1'b1; cyc(30);
    check1("torque", torque, 1'b1);
    check1("alarm", alarm, 1'b1);
    check1("dual", dual, 1'b0);
    cyc(50);
    check1("dual", dual, exp);
    shut = 1'b0; one_only = 1'b0; cyc(12);
    stop_pulse();
    check1("torque", torque, 1'b0);
    check1("dual", dual, 1'b0);
    check1("alarm", alarm, 1'b0);
  endtask
  // The second line follows after about 5 ms, inside the 11 ms window: no dual alarm.
  task automatic t_skew;
    wr(16'h4191, 8'h0B);
    skew = 8'h14; shut = 1'b1; cyc(80);
    check1("dual", dual, 1'b0);
    check1("alarm", alarm, 1'b1);
    shut = 1'b0; cyc(12);
    stop_pulse();
    check1("torque", torque, 1'b0);
    skew = 8'h00;
  endtask
  task automatic t_alm;
    wr(16'h419C, 8'h00);
    wr(16'h419A, 8'h01);
    off_on();
    stop_pulse();
    check1("torque", torque, 1'b1);
    almrst = 1'b1; cyc(6); almrst = 1'b0; cyc(2);
    check1("torque", torque, 1'b0);
  endtask
  task automatic t_hold;
    wr(16'h4198, 8'h14);
    shut = 1'b1; cyc(12); shut = 1'b0; cyc(10);
    clr = 1'b1; cyc(6); clr = 1'b0;
    check1("torque", torque, 1'b1);
    cyc(100); clr = 1'b1; cyc(6);
    check1("torque", torque, 1'b0);
    clr = 1'b0;
    wr(16'h4199, 8'h02);
    wr(16'h4198, 8'h05);
    shut = 1'b1; cyc(12); clr = 1'b1; shut = 1'b0; cyc(10);
    check1("torque", torque, 1'b1);
    cyc(30);
    check1("torque", torque, 1'b0);
    clr = 1'b0; cyc(2);
  endtask
  initial begin
    cyc(4); rst = 1'b0;
    t_regs(); t_stop();
    wr(16'h4190, 8'h01);
    t_dual(8'h0A, 1'b0); t_dual(8'h0B, 1'b1); t_skew();
    t_alm(); t_hold();
    complete_run();
  end
  // Whole run is about 620 cycles (about 5 us); this span is about twenty times that.
  initial begin
    #100us;
    failures++;
    complete_run();
  end
endmodule // tb_top
bind safe_torque_off_monitor sto_chk chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
  .FIRST_SHUTOFF_INPUT_IN(FIRST_SHUTOFF_INPUT_IN), .SECOND_SHUTOFF_INPUT_IN(SECOND_SHUTOFF_INPUT_IN),
  .STOP_INPUT_IN(STOP_INPUT_IN), .ALARM_RESET_INPUT_IN(ALARM_RESET_INPUT_IN), .REG_WRITE_IN(REG_WRITE_IN),
  .REG_READ_IN(REG_READ_IN), .REG_INDEX_IN(REG_INDEX_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RVALID_OUT(REG_RVALID_OUT), .REG_ERROR_OUT(REG_ERROR_OUT), .TORQUE_OFF_STATE_OUT(TORQUE_OFF_STATE_OUT),
  .SHUTOFF_ALARM_OUT(SHUTOFF_ALARM_OUT), .DUAL_CHANNEL_ALARM_OUT(DUAL_CHANNEL_ALARM_OUT));
`default_nettype wire
